// ### usc_pkg.sv
// Package for the serial channel status, interrupt and FIFO control block.
// Assumes a single clock domain and a byte-wide register port.
// Overview of operation
// - Ident nibble encodes pending cause codes.
// - Only highest-priority pending cause reported.
// - Data cause until FIFO below trigger.
// - Timeout after four idle character times.
// - Holding-empty cause cleared by ident read or data write.
// - Ident bits 5:4 zero, 7:6 show FIFO mode.
// - FIFO enable bit; toggling empties both FIFOs.
// - Clear bits empty one FIFO each.
// - Trigger select 1/4/8/14; control write-only.
// - Control bits 0/1 enable receiver/driver, low pins.
// - Control bit 3 gates interrupt request.
// - Loopback holds output mark, loops data.
// - Loopback keeps causes internal, no request.
// - Status bit 4 mirrors driver enable in loopback.
// - Error-bit set deferred during status read; overrun event dropped.
// - Data ready set on receive, cleared when empty.
// - Overrun on unread buffer or full FIFO.
// - Parity/framing flags travel with characters.
// - Break loads one zero character with flag.
// - Holding-empty set on empty, cleared on write.
// - Transmitter idle only when all empty.
// - FIFO error bit while flagged characters remain.
// - Line errors raise first cause; reset 0x60.
// - Four enable bits gate the five causes.
package usc_pkg;
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_IE     = 3'h1;
  localparam logic [2:0] ADDR_IDENT  = 3'h2;
  localparam logic [2:0] ADDR_XCTL   = 3'h4;
  localparam logic [2:0] ADDR_LSTAT  = 3'h5;
  localparam logic [2:0] ADDR_HSTAT  = 3'h6;
  localparam logic [7:0] LSTAT_RESET = 8'h60;
  localparam logic [7:0] IDENT_RESET = 8'h01;
  localparam logic [3:0] ID_NONE     = 4'h1;
  localparam logic [3:0] ID_LINE     = 4'h6;
  localparam logic [3:0] ID_DATA     = 4'h4;
  localparam logic [3:0] ID_TMO      = 4'hc;
  localparam logic [3:0] ID_HOLDING_EMPTY_FLAG     = 4'h2;
  localparam logic [3:0] ID_HS       = 4'h0;
  localparam int         FC_EN = 0, FC_RCLR = 1, FC_TCLR = 2, FC_TRIG = 6;
  localparam int         XC_RXEN = 0, XC_TXEN = 1, XC_IRQ = 3, XC_LOOP = 4;
  localparam logic [4:0] TRIG_1 = 5'h01, TRIG_4 = 5'h04, TRIG_8 = 5'h08, TRIG_14 = 5'h0e;
  localparam int         TMO_CHARS   = 4;
  localparam int         BITS_PER_CH = 10;
endpackage

// ### usc_ctrl.sv
// Status, interrupt identification, FIFO control and transceiver control of one channel.
// Assumes a serial engine on clk that reports receive/transmit events as one-cycle pulses.
`timescale 1ns/100ps
module usc_ctrl #(
  parameter int DEPTH    = 16,
  parameter int BIT_CLKS = 2170
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port.
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Serial engine, receive side.
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_framing_err,
  input  wire logic       rx_break,
  // Serial engine, transmit side.
  output logic            tx_char_valid,
  output logic      [7:0] tx_char,
  input  wire logic       tx_shift_busy,
  input  wire logic       tx_shift_out,
  output logic            rx_shift_in,
  // Pins.
  input  wire logic       line_rx_pin,
  output logic            line_tx_pin,
  output logic            rx_enable_n,
  output logic            tx_enable_n,
  output logic            irq_n
);
  import usc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int TMO_CLKS = TMO_CHARS * BITS_PER_CH * BIT_CLKS;

  logic [7:0] ie, xctl, lstat;
  logic       fifo_en, rd_q, head_posted;
  logic [1:0] trig_sel;
  logic [7:0] rx_mem [DEPTH];
  logic [2:0] rx_flg [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
  logic [AW:0]   rx_cnt, tx_cnt, err_cnt;
  logic       holding_empty_flag_pend, tmo_pend, rx_sync1, rx_sync2;
  logic [31:0] tmo_ctr;
  logic [4:0] trig;
  logic [3:0] ident;
  logic       hs_delta;

  // Command decode used by several processes.
  wire w_data  = wr && addr == ADDR_DATA;
  wire w_fc    = wr && addr == ADDR_IDENT;
  wire r_data  = rd && addr == ADDR_DATA;
  wire r_ident = rd && addr == ADDR_IDENT;
  wire r_lstat = rd && addr == ADDR_LSTAT;
  wire r_hstat = rd && addr == ADDR_HSTAT;
  wire loop    = xctl[XC_LOOP];
  wire [AW:0] cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
  wire rx_full = rx_cnt >= cap;
  wire rx_pop  = r_data && rx_cnt != '0;
  wire rx_push = rx_char_valid && !rx_full;
  wire tx_full = tx_cnt >= cap;
  wire tx_push = w_data && !tx_full;
  // A hand-off in flight has not yet raised busy, so it blocks a second pop.
  wire tx_pop  = tx_cnt != '0 && !tx_shift_busy && !tx_char_valid;
  wire fc_rclr = w_fc && wdata[FC_EN] && wdata[FC_RCLR];
  wire fc_tclr = w_fc && wdata[FC_EN] && wdata[FC_TCLR];
  wire mode_chg = w_fc && (wdata[FC_EN] != fifo_en);
  wire rx_flush = fc_rclr || mode_chg;
  wire tx_flush = fc_tclr || mode_chg;
  wire [2:0] head_flg = rx_flg[rx_rp];
  wire [2:0] in_flg = {rx_break, rx_framing_err, rx_parity_err & ~rx_break};
  wire in_bad = |in_flg;
  wire head_bad = rx_cnt != '0 && |head_flg;

  // Trigger level lookup.
  function automatic logic [4:0] trig_of(input logic [1:0] s);
    case (s)
      2'b00: trig_of = TRIG_1;
      2'b01: trig_of = TRIG_4;
      2'b10: trig_of = TRIG_8;
      default: trig_of = TRIG_14;
    endcase
  endfunction
  assign trig = fifo_en ? trig_of(trig_sel) : TRIG_1;

  // FIFO control register; write-only, fields take effect only with bit 0 set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_en  <= 1'b0;
      trig_sel <= 2'b00;
    end else if (w_fc) begin
      fifo_en <= wdata[FC_EN];
      if (wdata[FC_EN]) begin
        trig_sel <= wdata[FC_TRIG +: 2];
      end
    end
  end

  // Interrupt enable and transceiver control registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ie   <= 8'h00;
      xctl <= 8'h00;
    end else if (wr) begin
      if (addr == ADDR_IE) begin
        ie <= {4'h0, wdata[3:0]};
      end
      if (addr == ADDR_XCTL) begin
        xctl <= {3'h0, wdata[4:0]};
      end
    end
  end

  // Receive FIFO with per-entry error flags; a full FIFO drops the new character.
  always_ff @(posedge clk) begin
    if (!rst_n || rx_flush) begin
      rx_wp   <= '0;
      rx_rp   <= '0;
      rx_cnt  <= '0;
      err_cnt <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp] <= rx_break ? 8'h00 : rx_char;
        rx_flg[rx_wp] <= in_flg;
        rx_wp <= AW'(rx_wp + 1'b1);
      end
      if (rx_pop) begin
        rx_rp <= AW'(rx_rp + 1'b1);
      end
      rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      err_cnt <= err_cnt + (AW+1)'(rx_push && in_bad)
                         - (AW+1)'(rx_pop && |head_flg);
    end
  end

  // Transmit FIFO, drained into the shift engine whenever it is idle.
  always_ff @(posedge clk) begin
    if (!rst_n || tx_flush) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= wdata;
        tx_wp <= AW'(tx_wp + 1'b1);
      end
      if (tx_pop) begin
        tx_rp <= AW'(tx_rp + 1'b1);
      end
      tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // Hand-off to the shift engine; the flush never touches the shifter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_char_valid <= 1'b0;
      tx_char       <= 8'h00;
    end else begin
      tx_char_valid <= tx_pop && !tx_flush;
      tx_char       <= tx_mem[tx_rp];
    end
  end

  // A status read stretches over the strobe cycle; its trailing edge is the cycle after.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= r_lstat || r_hstat;
    end
  end

  // Head flags post once per head character, so a status read really clears them.
  always_ff @(posedge clk) begin
    if (!rst_n || rx_flush || rx_pop) begin
      head_posted <= 1'b0;
    end else if (rx_cnt != '0 && !rd_q && !r_lstat) begin
      head_posted <= 1'b1;
    end
  end

  // Line status sticky error bits and holding-empty.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lstat <= LSTAT_RESET;
    end else begin
      // Overrun: a new event during the read clears at the trailing edge instead.
      if (r_lstat) begin
        lstat[1] <= 1'b0;
      end else if (rx_char_valid && rx_full) begin
        lstat[1] <= !rd_q;
      end
      // Errors of the head character; plain mode keeps them sticky until read.
      if (r_lstat) begin
        lstat[4:2] <= 3'b000;
      end else if (!rd_q && !head_posted) begin
        lstat[4:2] <= lstat[4:2] | (head_bad ? head_flg : 3'b000);
      end
      if (w_data || tx_push) begin
        lstat[5] <= 1'b0;
      end else if (tx_cnt == '0 || tx_flush) begin
        lstat[5] <= 1'b1;
      end
    end
  end

  // Holding-empty cause: raised on empty edge, dropped by ident read or data write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holding_empty_flag_pend <= 1'b1;
    end else if (w_data) begin
      holding_empty_flag_pend <= 1'b0;
    end else if (tx_cnt != '0 && tx_pop && tx_cnt == (AW+1)'(1)) begin
      holding_empty_flag_pend <= 1'b1;
    end else if (r_ident && ident == ID_HOLDING_EMPTY_FLAG) begin
      holding_empty_flag_pend <= 1'b0;
    end
  end

  // Character timeout: four idle character times with data held.
  always_ff @(posedge clk) begin
    if (!rst_n || rx_push || rx_pop || rx_cnt == '0 || !fifo_en) begin
      tmo_ctr  <= '0;
      tmo_pend <= 1'b0;
    end else if (tmo_ctr >= 32'(TMO_CLKS - 1)) begin
      tmo_pend <= 1'b1;
    end else begin
      tmo_ctr <= tmo_ctr + 32'h1;
    end
  end

  // Handshake delta: no modem inputs exist, so nothing sets it; a handshake status read only clears it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_delta <= 1'b0;
    end else if (r_hstat) begin
      hs_delta <= 1'b0;
    end
  end

  // Cause priority: line, data/timeout, holding empty, handshake.
  wire c_line = ie[2] && (lstat[1] || |lstat[4:2]);
  wire c_data = ie[0] && rx_cnt != '0 && 32'(rx_cnt) >= 32'(trig);
  wire c_tmo  = ie[0] && tmo_pend;
  wire c_holding_empty_flag = ie[1] && holding_empty_flag_pend && lstat[5];
  wire c_hs   = ie[3] && hs_delta;
  always_comb begin
    if (c_line)      ident = ID_LINE;
    else if (c_data) ident = ID_DATA;
    else if (c_tmo)  ident = ID_TMO;
    else if (c_holding_empty_flag) ident = ID_HOLDING_EMPTY_FLAG;
    else if (c_hs)   ident = ID_HS;
    else             ident = ID_NONE;
  end

  // Read data mux; all reads register into the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        ADDR_DATA:  rdata <= rx_mem[rx_rp];
        ADDR_IE:    rdata <= ie;
        ADDR_IDENT: rdata <= {{2{fifo_en}}, 2'b00, ident};
        ADDR_XCTL:  rdata <= xctl;
        ADDR_LSTAT: rdata <= {fifo_en && err_cnt != '0,
                              tx_cnt == '0 && !tx_shift_busy && !tx_char_valid,
                              lstat[5:1], rx_cnt != '0};
        ADDR_HSTAT: rdata <= {3'b000, loop && xctl[XC_TXEN], 3'b000, hs_delta};
        default:    rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Line input synchroniser; loopback disconnects it and feeds the shifter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
    end else begin
      rx_sync1 <= line_rx_pin;
      rx_sync2 <= rx_sync1;
    end
  end

  // Pins are registered; loopback forces them inactive and mark.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_tx_pin <= 1'b1;
      rx_enable_n <= 1'b1;
      tx_enable_n <= 1'b1;
      irq_n       <= 1'b1;
      rx_shift_in <= 1'b1;
    end else begin
      line_tx_pin <= loop ? 1'b1 : tx_shift_out;
      rx_shift_in <= loop ? tx_shift_out : rx_sync2;
      rx_enable_n <= !(xctl[XC_RXEN] && !loop);
      tx_enable_n <= !(xctl[XC_TXEN] && !loop);
      irq_n       <= !(xctl[XC_IRQ] && !loop && ident != ID_NONE);
    end
  end

endmodule // usc_ctrl

// ### usc_ctrl_monitor.sv
// Assertions on the ports of usc_ctrl.
// Assumes one clock and the byte register port of usc_pkg.
`timescale 1ns/100ps
module usc_ctrl_monitor
  import usc_pkg::*;
(
  // Watched ports.
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       line_tx_pin,
  input wire logic       rx_enable_n,
  input wire logic       tx_enable_n,
  input wire logic       irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] xc;
  logic [7:0] ie;
  logic       fen;
  // Shadow copies of the control bits, since the body is not visible here.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xc  <= 8'h00;
      ie  <= 8'h00;
      fen <= 1'b0;
    end else if (wr) begin
      if (addr == ADDR_XCTL) xc <= wdata;
      if (addr == ADDR_IE) ie <= wdata;
      if (addr == ADDR_IDENT) fen <= wdata[FC_EN];
    end
  end
  sequence s_rd_ident;
    rd && addr == ADDR_IDENT;
  endsequence
  sequence s_rd_hstat;
    rd && addr == ADDR_HSTAT;
  endsequence
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_IDENT_ZERO: assert property (s_rd_ident |=> rdata[5:4] == 2'b00)
    else $error("ident bits 5:4 not zero");
  AST_IDENT_FIFO: assert property (s_rd_ident |=> rdata[7:6] == {2{$past(fen)}})
    else $error("ident bits 7:6 disagree with fifo mode");
  AST_HSTAT_BITS: assert property (s_rd_hstat |=> rdata[7:5] == 3'h0 && rdata[3:0] == 4'h0)
    else $error("handshake status unused bits set");
  AST_HSTAT_LOOP: assert property (s_rd_hstat ##0 xc[XC_LOOP] |=> rdata[4] == $past(xc[XC_TXEN]))
    else $error("handshake bit 4 does not mirror driver enable");
  AST_LOOP_PINS: assert property (xc[XC_LOOP] && $past(xc[XC_LOOP]) |->
    line_tx_pin && rx_enable_n && tx_enable_n && irq_n)
    else $error("pins active during loopback");
  AST_ENABLES: assert property (!xc[XC_LOOP] && $stable(xc) |->
    rx_enable_n == !xc[XC_RXEN] && tx_enable_n == !xc[XC_TXEN])
    else $error("transceiver enables disagree with control bits");
  AST_IRQ_GATE: assert property (!irq_n |-> $past(xc[XC_IRQ]) && !$past(xc[XC_LOOP])
    && $past(ie[3:0]) != 4'h0)
    else $error("interrupt request while gated off");
endmodule // usc_ctrl_monitor
bind usc_ctrl usc_ctrl_monitor mon (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .line_tx_pin(line_tx_pin), .rx_enable_n(rx_enable_n),
  .tx_enable_n(tx_enable_n), .irq_n(irq_n));

// ### usc_shift_model.sv
// Behavioural transmit shifter on the far side of the channel control block.
// Assumes tx_char_valid is a one-cycle pulse; busy spans hold_clks cycles.
`timescale 1ns/100ps
module usc_shift_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Hand-over from the block.
  input  wire logic       tx_char_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic [7:0] hold_clks,
  // Shifter state.
  output logic            tx_shift_busy,
  output logic            tx_shift_out,
  output logic      [7:0] last_char,
  output logic      [7:0] char_cnt
);
  logic [7:0] left;
  logic [9:0] frame;
  // Bits go out one a clock; the line rests at mark once the frame is spent.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left     <= 8'h00;
      frame    <= 10'h3ff;
      char_cnt <= 8'h00;
    end else if (tx_char_valid) begin
      left      <= hold_clks;
      frame     <= {1'b1, tx_char, 1'b0};
      last_char <= tx_char;
      char_cnt  <= char_cnt + 8'h01;
    end else begin
      frame <= {1'b1, frame[9:1]};
      if (left != 8'h00) left <= left - 8'h01;
    end
  end
  assign tx_shift_busy = (left != 8'h00);
  assign tx_shift_out  = frame[0];
endmodule // usc_shift_model

// ### usc_ctrl_tb_top.sv
// Self-checking bench for usc_ctrl; the bench stands in for the receive engine.
// Assumes usc_shift_model as transmit shifter and the monitor bound to the block.
`timescale 1ns/100ps
module usc_ctrl_tb_top;
  import usc_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       rxv = 1'b0, pe = 1'b0, fe = 1'b0, brk = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rxc = 8'h00, hold = 8'h0c, v;
  logic [7:0] rdata, tch, last_char, char_cnt;
  logic       tcv, busy, sout, rsin, txp, rxe_n, txe_n, irq_n;
  int         error_cnt = 0, checked = 0;
  initial forever #2 clk = ~clk;
  usc_ctrl #(.BIT_CLKS(2)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_char_valid(rxv), .rx_char(rxc), .rx_parity_err(pe),
    .rx_framing_err(fe), .rx_break(brk), .tx_char_valid(tcv), .tx_char(tch),
    .tx_shift_busy(busy), .tx_shift_out(sout), .rx_shift_in(rsin), .line_rx_pin(1'b1),
    .line_tx_pin(txp), .rx_enable_n(rxe_n), .tx_enable_n(txe_n), .irq_n(irq_n));
  usc_shift_model sh (.clk(clk), .rst_n(rst_n), .tx_char_valid(tcv), .tx_char(tch),
    .hold_clks(hold), .tx_shift_busy(busy), .tx_shift_out(sout), .last_char(last_char),
    .char_cnt(char_cnt));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes drop for a cycle between transfers so no signal is driven twice at one edge.
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [2:0] a);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    rreg(a);
    chk(what, v, exp);
  endtask
  task automatic rx(input logic [7:0] c, input logic [2:0] f);
    rxv <= 1'b1;
    rxc <= c;
    {brk, fe, pe} <= f;
    @(posedge clk);
    rxv <= 1'b0;
    {brk, fe, pe} <= 3'h0;
    @(posedge clk);
  endtask
  task automatic t_prio;
    rchk(ADDR_LSTAT, LSTAT_RESET, "line_status");
    rchk(ADDR_IDENT, IDENT_RESET, "interrupt_ident");
    chk("pins", {4'h0, txp, rxe_n, txe_n, irq_n}, 8'h0f);
    wreg(ADDR_IE, 8'h02);
    rchk(ADDR_IDENT, 8'h02, "holding empty ident");
    rchk(ADDR_IDENT, 8'h01, "ident after read");
    wreg(ADDR_IE, 8'h07);
    rx(8'h33, 3'h1);
    rchk(ADDR_IDENT, 8'h06, "line ident");
    rchk(ADDR_LSTAT, 8'h65, "parity status");
    rchk(ADDR_IDENT, 8'h04, "data ident");
    rchk(ADDR_DATA, 8'h33, "receive_buffer");
    rchk(ADDR_LSTAT, 8'h60, "status drained");
    rx(8'h11, 3'h0);
    rx(8'h22, 3'h0);
    rchk(ADDR_LSTAT, 8'h63, "overrun");
    rreg(ADDR_DATA);
    $display("test prio done");
  endtask
  task automatic t_fifo;
    logic [4:0] lvl [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
    wreg(ADDR_IE, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wreg(ADDR_IDENT, {i[1:0], 6'h03});
      for (int n = 1; n < lvl[i]; n++) rx(8'(n), 3'h0);
      if (lvl[i] > 5'h01) rchk(ADDR_IDENT, 8'hc1, "below trigger");
      rx(8'h55, 3'h0);
      rchk(ADDR_IDENT, 8'hc4, "at trigger");
    end
    rreg(ADDR_DATA);
    rchk(ADDR_IDENT, 8'hc1, "one under trigger");
    repeat (100) @(posedge clk);
    rchk(ADDR_IDENT, 8'hcc, "timeout");
    rreg(ADDR_DATA);
    rchk(ADDR_IDENT, 8'hc1, "timeout cleared");
    repeat (5) rx(8'h77, 3'h0);
    rchk(ADDR_LSTAT, 8'h63, "fifo overrun");
    wreg(ADDR_IDENT, 8'hc3);
    rchk(ADDR_LSTAT, 8'h60, "rx cleared");
    rx(8'h12, 3'h0);
    wreg(ADDR_IDENT, 8'h00);
    rchk(ADDR_LSTAT, 8'h60, "mode switch empties");
    rchk(ADDR_IDENT, 8'h01, "ident plain mode");
    $display("test fifo done");
  endtask
  task automatic t_err;
    wreg(ADDR_IDENT, 8'h07);
    wreg(ADDR_IE, 8'h05);
    rx(8'h21, 3'h2);
    rx(8'h22, 3'h0);
    rx(8'h00, 3'h4);
    rchk(ADDR_IDENT, 8'hc6, "line first");
    rchk(ADDR_LSTAT, 8'he9, "framing at head");
    rreg(ADDR_DATA);
    rchk(ADDR_LSTAT, 8'he1, "fifo error kept");
    rreg(ADDR_DATA);
    rchk(ADDR_LSTAT, 8'hf1, "break at head");
    rreg(ADDR_DATA);
    rchk(ADDR_LSTAT, 8'h60, "errors gone");
    $display("test err done");
  endtask
  task automatic t_tx;
    wreg(ADDR_IE, 8'h02);
    hold <= 8'h20;
    wreg(ADDR_DATA, 8'ha1);
    wreg(ADDR_DATA, 8'ha2);
    wreg(ADDR_DATA, 8'ha3);
    rchk(ADDR_LSTAT, 8'h00, "tx pending");
    repeat (150) @(posedge clk);
    chk("sent count", char_cnt, 8'h03);
    chk("last sent", last_char, 8'ha3);
    rchk(ADDR_LSTAT, 8'h60, "tx idle");
    rchk(ADDR_IDENT, 8'hc2, "holding empty");
    rchk(ADDR_IDENT, 8'hc1, "holding read");
    $display("test tx done");
  endtask
  task automatic t_loop;
    int n;
    wreg(ADDR_XCTL, 8'h0b);
    wreg(ADDR_DATA, 8'h5a);
    repeat (60) @(posedge clk);
    chk("pins", {4'h0, txp, rxe_n, txe_n, irq_n}, 8'h08);
    wreg(ADDR_XCTL, 8'h1b);
    repeat (2) @(posedge clk);
    chk("loop pins", {4'h0, txp, rxe_n, txe_n, irq_n}, 8'h0f);
    rchk(ADDR_HSTAT, 8'h10, "handshake_status");
    rchk(ADDR_IDENT, 8'hc2, "loop pending");
    // A zero byte gives start plus eight data bits low on the looped input; the pin stays mark.
    wreg(ADDR_DATA, 8'h00);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (!rsin) n++;
      if (!txp) n += 100;
    end
    chk("looped zeros", n[7:0], 8'h09);
    wreg(ADDR_XCTL, 8'h03);
    repeat (2) @(posedge clk);
    chk("gated pins", {4'h0, txp, rxe_n, txe_n, irq_n}, 8'h09);
    $display("test loop done");
  endtask
  task automatic give_verdict;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run takes under 600 cycles; the watchdog allows over fifteen times that.
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_prio;
    t_fifo;
    t_err;
    t_tx;
    t_loop;
    give_verdict;
  end
endmodule // usc_ctrl_tb_top
